// ---- design/irq_ctrl_pkg.sv ----
// Purpose: Shared constants and types for the vectored interrupt controller
// Assumes: 32-bit classic Wishbone slave, 50 MHz system clock
// Notes: Register map offsets are byte addresses
package irq_ctrl_pkg;
    localparam int NUM_SRC = 128;
    localparam int NUM_SW = 8;
    localparam int SRC_W = 7;
    localparam int PRI_W = 4;
    localparam int VEC_W = 9;
    localparam int PRI_WORDS = NUM_SRC / 8;
    // ******************************
    // Register map
    // ******************************
    localparam logic [11:0] OFF_CTRL = 12'h000;
    localparam logic [11:0] OFF_MASK = 12'h004;
    localparam logic [11:0] OFF_ACK = 12'h008;
    localparam logic [11:0] OFF_SWSET = 12'h00c;
    localparam logic [11:0] OFF_SWCLR = 12'h010;
    localparam logic [11:0] OFF_STATUS = 12'h014;
    localparam logic [11:0] OFF_PEND0 = 12'h020;
    localparam logic [11:0] OFF_PRI0 = 12'h100;
    localparam logic [11:0] OFF_PRI_END = 12'h140;
    localparam logic [11:0] OFF_PEND_END = 12'h030;
    localparam logic [3:0] MASK_RST = 4'h0;
    localparam logic [PRI_W-1:0] PRI_RST = 4'h0;
    localparam logic [VEC_W-1:0] VEC_BASE = 9'h000;
    localparam int CTRL_EN_BIT = 0;
    localparam int ST_REQ_BIT = 31;
    localparam logic [31:0] BAD_READ = 32'h0000_0000;

    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [3:0] sel;
        logic [11:0] adr;
        logic [31:0] dat;
    } wb_req_s;

    typedef struct packed {
        logic valid;
        logic [PRI_W-1:0] pri;
        logic [SRC_W-1:0] src;
    } cand_s;

    typedef enum logic [2:0] {
        CORE_IDLE = 3'b001,
        CORE_REQ = 3'b010,
        CORE_SERV = 3'b100
    } core_state_e;
endpackage

// ---- design/irq_pick.sv ----
// Purpose: Two-way priority pick for the arbitration tree
// Assumes: Lower source index wins a tie
// Notes: Pure combinational
`timescale 1ns/100ps
module irq_pick
    import irq_ctrl_pkg::*;
(
    input wire cand_s a_in,
    input wire cand_s b_in,
    output cand_s win_out
);
    wire b_wins = b_in.valid && (!a_in.valid || (b_in.pri > a_in.pri));
    assign win_out = b_wins ? b_in : a_in;
endmodule // irq_pick

// ---- design/vectored_irq_controller.sv ----
// Purpose: Priority-based preemptive vectored interrupt controller
// Assumes: Request inputs are levels synchronous to clk_in
// Notes: Wishbone classic slave; ack one cycle after request
//
// Contract
// - Up to 128 sources, each serviced with its own distinct 9-bit vector.
// - Every source has a software-written priority among sixteen levels.
// - Equal-priority ties resolve by fixed order: lowest source number wins.
// - A request above the level in service preempts and reaches the core.
// - Requests not above the current priority mask are withheld.
// - Eight software-set sources arbitrate and vector like peripheral sources.
// - The non-maskable input goes straight to the critical interrupt output.
`timescale 1ns/100ps
module vectored_irq_controller
    import irq_ctrl_pkg::*;
(
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic wb_cyc_in,
    input wire logic wb_stb_in,
    input wire logic wb_we_in,
    input wire logic [3:0] wb_sel_in,
    input wire logic [11:0] wb_adr_in,
    input wire logic [31:0] wb_dat_in,
    output logic [31:0] wb_dat_out,
    output logic wb_ack_out,
    input wire logic [NUM_SRC-NUM_SW-1:0] periph_irq_in,
    input wire logic nmi_in,
    input wire logic core_ack_in,
    output logic core_irq_out,
    output logic [VEC_W-1:0] core_vec_out,
    output logic core_crit_out
);
    // ******************************
    // Bus decode
    // ******************************
    wb_req_s req;
    assign req = '{cyc: wb_cyc_in, stb: wb_stb_in, we: wb_we_in, sel: wb_sel_in,
                   adr: wb_adr_in, dat: wb_dat_in};
    wire bus_go = req.cyc && req.stb && !wb_ack_out;
    // Writes land on the edge where the master samples ack high
    wire wr_go = req.cyc && req.stb && req.we && wb_ack_out;
    wire hit_ctrl = (req.adr == OFF_CTRL);
    wire hit_mask = (req.adr == OFF_MASK);
    wire hit_ack = (req.adr == OFF_ACK);
    wire hit_swset = (req.adr == OFF_SWSET);
    wire hit_swclr = (req.adr == OFF_SWCLR);
    wire hit_status = (req.adr == OFF_STATUS);
    wire hit_pend = (req.adr >= OFF_PEND0) && (req.adr < OFF_PEND_END);
    wire hit_pri = (req.adr >= OFF_PRI0) && (req.adr < OFF_PRI_END);
    wire [1:0] pend_idx = req.adr[3:2];
    wire [3:0] pri_idx = req.adr[5:2];

    // ******************************
    // State
    // ******************************
    logic en_q;
    logic [3:0] mask_q;
    logic [NUM_SW-1:0] sw_q;
    logic [NUM_SW-1:0] sw_d;
    logic [PRI_W-1:0] pri_q [NUM_SRC];
    logic [PRI_W-1:0] cur_q;
    logic [PRI_W-1:0] cur_d;
    logic [PRI_W-1:0] stack_q [16];
    logic [4:0] sp_q;
    logic [4:0] sp_d;
    logic req_q;
    logic [VEC_W-1:0] vec_q;
    logic [PRI_W-1:0] req_pri_q;
    logic [31:0] rdat_d;
    core_state_e st_q;
    core_state_e st_d;

    wire [NUM_SRC-1:0] raw_req = {sw_q, periph_irq_in};
    wire sw_set_go = wr_go && hit_swset;
    wire sw_clr_go = wr_go && hit_swclr;
    // Set wins over a clear in the same write cycle window
    assign sw_d = (sw_q & ~(sw_clr_go ? req.dat[NUM_SW-1:0] : '0))
                | (sw_set_go ? req.dat[NUM_SW-1:0] : '0);

    // ******************************
    // Arbitration tree
    // ******************************
    cand_s lvl [2*NUM_SRC-1];
    genvar gi;
    generate
        for (gi = 0; gi < NUM_SRC; gi++)
        begin : g_leaf
            assign lvl[NUM_SRC-1+gi] = '{valid: raw_req[gi], pri: pri_q[gi],
                                         src: SRC_W'(gi)};
        end
        for (gi = 0; gi < NUM_SRC-1; gi++)
        begin : g_node
            irq_pick u_pick (
                .a_in(lvl[2*gi+1]),
                .b_in(lvl[2*gi+2]),
                .win_out(lvl[gi])
            );
        end
    endgenerate
    cand_s best;
    assign best = lvl[0];
    // Level 0 never interrupts, so mask 0 still blocks priority 0
    wire above = best.valid && en_q && (best.pri > mask_q) && (best.pri > cur_q);
    wire [VEC_W-1:0] best_vec = VEC_BASE + VEC_W'(best.src);
    wire replace = above && (!req_q || best.pri > req_pri_q);
    wire take = req_q && core_ack_in;
    wire eoi = wr_go && hit_ack && (sp_q != 5'h00);

    // ******************************
    // Core-facing sequencing
    // ******************************
    always_comb
    begin
        st_d = st_q;
        cur_d = cur_q;
        sp_d = sp_q;
        case (st_q)
            CORE_IDLE, CORE_SERV:
            begin
                if (replace)
                begin
                    st_d = CORE_REQ;
                end
            end
            CORE_REQ:
            begin
                if (take)
                begin
                    st_d = CORE_SERV;
                end
            end
            default:
            begin
                st_d = CORE_IDLE;
            end
        endcase
        if (take)
        begin
            cur_d = req_pri_q;
            sp_d = sp_q + 5'h01;
        end
        else if (eoi)
        begin
            cur_d = stack_q[4'(sp_q - 5'h01)];
            sp_d = sp_q - 5'h01;
            if (st_q == CORE_SERV && sp_q == 5'h01 && !replace)
            begin
                st_d = CORE_IDLE;
            end
        end
    end

    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            st_q <= CORE_IDLE;
            req_q <= 1'b0;
            vec_q <= '0;
            req_pri_q <= PRI_RST;
            cur_q <= PRI_RST;
            sp_q <= 5'h00;
        end
        else
        begin
            st_q <= st_d;
            cur_q <= cur_d;
            sp_q <= sp_d;
            if (replace && !take)
            begin
                req_q <= 1'b1;
                vec_q <= best_vec;
                req_pri_q <= best.pri;
            end
            else if (take)
            begin
                req_q <= 1'b0;
            end
        end
    end

    // Saved levels for nested service; depth 16 covers every level
    always_ff @(posedge clk_in)
    begin
        if (take && !sp_q[4])
        begin
            stack_q[sp_q[3:0]] <= cur_q;
        end
    end

    // ******************************
    // Register writes
    // ******************************
    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            en_q <= 1'b0;
            mask_q <= MASK_RST;
            sw_q <= '0;
        end
        else
        begin
            sw_q <= sw_d;
            if (wr_go && hit_ctrl && req.sel[0])
            begin
                en_q <= req.dat[CTRL_EN_BIT];
            end
            if (wr_go && hit_mask && req.sel[0])
            begin
                mask_q <= req.dat[3:0];
            end
        end
    end

    generate
        for (gi = 0; gi < NUM_SRC; gi++)
        begin : g_pri
            localparam int W = gi / 8;
            localparam int F = gi % 8;
            always_ff @(posedge clk_in or posedge rst_in)
            begin
                if (rst_in)
                begin
                    pri_q[gi] <= PRI_RST;
                end
                else if (wr_go && hit_pri && pri_idx == 4'(W) && req.sel[F/2])
                begin
                    pri_q[gi] <= req.dat[F*4 +: 4];
                end
            end
        end
    endgenerate

    // ******************************
    // Register reads
    // ******************************
    logic [31:0] pri_word;
    always_comb
    begin
        pri_word = '0;
        for (int k = 0; k < 8; k++)
        begin
            pri_word[k*4 +: 4] = pri_q[{pri_idx, 3'(k)}];
        end
    end

    always_comb
    begin
        rdat_d = BAD_READ;
        if (hit_ctrl)
        begin
            rdat_d = {31'h0, en_q};
        end
        else if (hit_mask)
        begin
            rdat_d = {28'h0, mask_q};
        end
        else if (hit_ack)
        begin
            rdat_d = {23'h0, vec_q};
        end
        else if (hit_swset || hit_swclr)
        begin
            rdat_d = {24'h0, sw_q};
        end
        else if (hit_status)
        begin
            rdat_d = {req_q, 14'h0, core_crit_out, 3'h0, sp_q, cur_q, best.pri};
        end
        else if (hit_pend)
        begin
            rdat_d = raw_req[pend_idx*32 +: 32];
        end
        else if (hit_pri)
        begin
            rdat_d = pri_word;
        end
    end

    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            wb_ack_out <= 1'b0;
            wb_dat_out <= '0;
        end
        else
        begin
            wb_ack_out <= bus_go;
            if (bus_go && !req.we)
            begin
                wb_dat_out <= rdat_d;
            end
        end
    end

    // Critical path bypasses mask and arbitration
    assign core_crit_out = nmi_in;
    assign core_irq_out = req_q;
    assign core_vec_out = vec_q;
endmodule // vectored_irq_controller

// ---- sim/vic_sva.sv ----
// Purpose: Port checker for the vectored interrupt controller
// Assumes: Classic Wishbone slave, one clock domain
// Notes: Bound to the design at the foot of this file
`timescale 1ns/100ps
module vic_sva
    import irq_ctrl_pkg::*;
(
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic wb_cyc_in,
    input wire logic wb_stb_in,
    input wire logic wb_we_in,
    input wire logic [11:0] wb_adr_in,
    input wire logic [31:0] wb_dat_out,
    input wire logic wb_ack_out,
    input wire logic nmi_in,
    input wire logic core_ack_in,
    input wire logic core_irq_out,
    input wire logic [VEC_W-1:0] core_vec_out,
    input wire logic core_crit_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (rst_in);
    nmi_path_a: assert property (core_crit_out == nmi_in)
        else $error("crit differs from nmi");
    irq_hold_a: assert property (core_irq_out && !core_ack_in |=> core_irq_out)
        else $error("request dropped unacked");
    irq_drop_a: assert property (core_irq_out && core_ack_in |=> !core_irq_out)
        else $error("request kept after ack");
    vec_range_a: assert property (core_irq_out |-> core_vec_out < 9'h080)
        else $error("vector beyond sources");
    bus_ack_a: assert property (wb_cyc_in && wb_stb_in && !wb_ack_out |=> wb_ack_out)
        else $error("bus ack late");
    ack_pulse_a: assert property (wb_ack_out |=> !wb_ack_out)
        else $error("bus ack too long");
    ack_cause_a: assert property (wb_ack_out |-> $past(wb_cyc_in && wb_stb_in))
        else $error("bus ack unrequested");
    bad_read_a: assert property (wb_ack_out && !wb_we_in && wb_adr_in[11]
        |-> wb_dat_out == BAD_READ)
        else $error("unmapped read not zero");
endmodule // vic_sva

bind vectored_irq_controller vic_sva vic_sva_i (.clk_in(clk_in), .rst_in(rst_in),
    .wb_cyc_in(wb_cyc_in), .wb_stb_in(wb_stb_in), .wb_we_in(wb_we_in),
    .wb_adr_in(wb_adr_in), .wb_dat_out(wb_dat_out), .wb_ack_out(wb_ack_out),
    .nmi_in(nmi_in), .core_ack_in(core_ack_in), .core_irq_out(core_irq_out),
    .core_vec_out(core_vec_out), .core_crit_out(core_crit_out));

// ---- sim/core_model.sv ----
// Purpose: Core side that acknowledges interrupt requests
// Assumes: Ack is a one-cycle pulse sampled with the request
// Notes: en_in low stalls the core so a request must stand
`timescale 1ns/100ps
module core_model
(
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic en_in,
    input wire logic [3:0] lat_in,
    input wire logic irq_in,
    output logic ack_out
);
    logic [3:0] wait_q;
    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            wait_q <= 4'h0;
            ack_out <= 1'b0;
        end
        else if (en_in && irq_in && !ack_out && wait_q >= lat_in)
        begin
            ack_out <= 1'b1;
            wait_q <= 4'h0;
        end
        else
        begin
            ack_out <= 1'b0;
            wait_q <= (irq_in && !ack_out) ? wait_q + 4'h1 : 4'h0;
        end
    end
endmodule // core_model

// ---- sim/vectored_irq_controller_tb.sv ----
// Purpose: Self-checking bench for the vectored interrupt controller
// Assumes: Ack one cycle after a bus request
// Notes: Core model stalls where a request must stand
`timescale 1ns/100ps
module vectored_irq_controller_tb
    import irq_ctrl_pkg::*;
;
    logic clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic nmi = 1'b0;
    logic en = 1'b0;
    logic [11:0] adr = 12'h000;
    logic [31:0] wdat = 32'h0;
    logic [119:0] periph = 120'h0;
    logic [31:0] rdout, rdat;
    logic ack, bus_ack, irq, crit;
    logic [VEC_W-1:0] vec;
    int fails = 0;
    int tests_run = 0;

    always #10 clk_in = ~clk_in;

    vectored_irq_controller vectored_irq_controller_i (.clk_in(clk_in), .rst_in(rst_in),
        .wb_cyc_in(cyc), .wb_stb_in(stb), .wb_we_in(we), .wb_sel_in(4'hf),
        .wb_adr_in(adr), .wb_dat_in(wdat), .wb_dat_out(rdout), .wb_ack_out(bus_ack),
        .periph_irq_in(periph), .nmi_in(nmi), .core_ack_in(ack),
        .core_irq_out(irq), .core_vec_out(vec), .core_crit_out(crit));
    core_model core_model_i (.clk_in(clk_in), .rst_in(rst_in), .en_in(en),
        .lat_in(4'h2), .irq_in(irq), .ack_out(ack));

    task automatic check(input string nm, input logic [31:0] seen, exp);
        tests_run++;
        if (seen !== exp)
        begin
            fails++;
            $display("CHECK FAILED %s exp %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic wb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk_in);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        do @(posedge clk_in); while (bus_ack !== 1'b1);
        rdat = rdout;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask

    task automatic wait_irq(input logic v);
        for (int i = 0; i < 20 && irq !== v; i++) @(posedge clk_in);
        check("irq", irq, v);
    endtask

    task automatic final_report;
        $display("comparisons %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    initial
    begin
        repeat (5) @(posedge clk_in);
        rst_in <= 1'b0;
        nmi <= 1'b1;
        repeat (2) @(posedge clk_in);
        check("crit", crit, 32'h1);
        check("irq", irq, 32'h0);
        nmi <= 1'b0;
        wb(1'b0, OFF_MASK, 32'h0);
        check("mask", rdat, 32'(MASK_RST));
        check("crit", crit, 32'h0);
        // Sources 5 and 9 share a level, 124 sits above them
        wb(1'b1, OFF_PRI0, 32'h0030_0000);
        wb(1'b1, OFF_PRI0 + 12'h004, 32'h0000_0030);
        wb(1'b1, OFF_PRI0 + 12'h03c, 32'h0007_0000);
        wb(1'b1, OFF_MASK, 32'h3);
        wb(1'b1, OFF_CTRL, 32'h1);
        periph <= 120'h220;
        repeat (8) @(posedge clk_in);
        check("masked", irq, 32'h0);
        wb(1'b1, OFF_MASK, 32'h2);
        wait_irq(1'b1);
        check("tie", vec, 32'h5);
        repeat (6) @(posedge clk_in);
        check("held", vec, 32'h5);
        wb(1'b1, OFF_SWSET, 32'h10);
        wb(1'b0, OFF_SWSET, 32'h0);
        check("sw", rdat, 32'h10);
        wb(1'b0, 12'h800, 32'h0);
        check("bad", rdat, BAD_READ);
        repeat (3) @(posedge clk_in);
        check("preempt", vec, 32'h7c);
        check("irq", irq, 32'h1);
        en <= 1'b1;
        wait_irq(1'b0);
        en <= 1'b0;
        wb(1'b1, OFF_SWCLR, 32'h10);
        repeat (6) @(posedge clk_in);
        check("below", irq, 32'h0);
        wb(1'b1, OFF_ACK, 32'h0);
        wait_irq(1'b1);
        check("resume", vec, 32'h5);
        final_report;
    end

    initial
    begin
        repeat (3000) @(posedge clk_in);
        fails++;
        final_report;
    end
endmodule // vectored_irq_controller_tb
